// file: design/cde_pkg.sv
// package for the cache diagnostic and error bank register block
// Operation
// - icache tag read: valid bit 21, tag 20 down to N, rest zero
// - dcache tag read: attribute 25:23, valid 22, tag 21 down to N
// - dcache attribute codes 000,010..110 defined; 111 reserved
// - data RAM read returns full 32-bit word without check bits
// - with ECC, errors in caches and TCM recorded in lockable entries
// - security present and fault control zero: error entries RAZ/WI non-secure
// - error entries reset on cold reset only
// - unprivileged access to error entries raises a memory access fault
// - cache error entries RAZ/WI when cache or ECC absent
// - bits 31:30 software field, cleared on allocation and cold reset
// - icache entry bit 16 selects tag or data RAM
// - icache location: way 15, index 14:5, word offset 4:2
// - dcache location: way 15:14, index 13:5, doubleword offset 4:2
// - dcache entry bit 17: single-bit or multi-bit error
// - locked entry not allocated by hardware; lock clears on cold reset
// - only one icache entry locked; other lock write ignored
// - only one dcache entry locked; other lock write ignored
// - bit 0 marks entry valid, zero after cold reset
// - location register selects way, set, offset, RAM type for reads
// - read registers RAZ/WI if inactive, unpowered or auto-invalidating
// - read registers RAZ non-secure with security, RAZ if cache absent
package cde_pkg;
	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] ADDR_IC_ERR0 = 32'hE001E100;
	localparam logic [31:0] ADDR_IC_ERR1 = 32'hE001E104;
	localparam logic [31:0] ADDR_DC_ERR0 = 32'hE001E110;
	localparam logic [31:0] ADDR_DC_ERR1 = 32'hE001E114;
	localparam logic [31:0] ADDR_TM_ERR0 = 32'hE001E120;
	localparam logic [31:0] ADDR_TM_DAT0 = 32'hE001E124;
	localparam logic [31:0] ADDR_TM_ERR1 = 32'hE001E128;
	localparam logic [31:0] ADDR_TM_DAT1 = 32'hE001E12C;
	localparam logic [31:0] ADDR_DC_READ = 32'hE001E200;
	localparam logic [31:0] ADDR_IC_READ = 32'hE001E204;
	localparam logic [31:0] ADDR_DC_LOC = 32'hE001E210;
	localparam logic [31:0] ADDR_IC_LOC = 32'hE001E214;
	// ----------------------------------------------------------------
	// field positions and masks
	// ----------------------------------------------------------------
	localparam int BIT_VALID = 0;
	localparam int BIT_LOCK = 1;
	localparam int BIT_IC_BANK = 16;
	localparam int BIT_DC_TYPE = 17;
	localparam int BIT_RAMSEL = 0;
	localparam logic [31:0] MASK_IC_ERR = 32'hC001FFFF;
	localparam logic [31:0] MASK_DC_ERR = 32'hC003FFFF;
	localparam logic [31:0] MASK_TM_ERR = 32'hDFFFFFFF;
	localparam logic [31:0] MASK_SOFTWARE_DEFINED_FIELD = 32'hC0000000;
	localparam logic [31:0] MASK_LOC_LOW = 32'h0000001D;
	// ----------------------------------------------------------------
	// reset values and attribute codes
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_ENTRY = 32'h00000000;
	localparam logic [31:0] RST_LOC = 32'h00000000;
	localparam logic [2:0] ATTR_CLEAN = 3'h0;
	localparam logic [2:0] ATTR_RESERVED = 3'h7;
endpackage : cde_pkg

// file: design/cde_regs.sv
// cache direct read and ECC error bank registers behind an APB slave
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module cde_regs
	import cde_pkg::*;
#(
	parameter bit ICACHE_PRESENT = 1'b1,
	parameter bit DCACHE_PRESENT = 1'b1,
	parameter bit ECC_PRESENT = 1'b1,
	parameter bit SECURITY_EXT = 1'b1,
	parameter int ICACHE_KB = 64,
	parameter int DCACHE_KB = 64
)
(
	// clock and cold reset
	input wire logic clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [2:0] pprot,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// memory system controls
	input wire logic nonsecure_fault_handling_control,
	input wire logic icache_active_control,
	input wire logic dcache_active_control,
	input wire logic cache_ram_power_domain,
	input wire logic cache_auto_invalidating,
	// cache RAM read side
	output logic [31:0] icache_read_location,
	output logic [31:0] dcache_read_location,
	input wire logic ic_ram_tag_valid,
	input wire logic [20:0] ic_ram_tag,
	input wire logic [31:0] ic_ram_data,
	input wire logic [2:0] dc_ram_attr,
	input wire logic dc_ram_tag_valid,
	input wire logic [21:0] dc_ram_tag,
	input wire logic [31:0] dc_ram_data,
	// error detection side
	input wire logic ic_err_valid,
	input wire logic ic_err_bank,
	input wire logic [13:0] ic_err_location,
	input wire logic dc_err_valid,
	input wire logic dc_err_multi,
	input wire logic dc_err_bank,
	input wire logic [13:0] dc_err_location,
	input wire logic tm_err_valid,
	input wire logic [28:2] tm_err_info,
	input wire logic [31:0] tm_err_data,
	output logic ic_err_full,
	output logic dc_err_full,
	output logic tm_err_full
);
	// ----------------------------------------------------------------
	// geometry and configuration
	// ----------------------------------------------------------------
	localparam int IC_N = $clog2(ICACHE_KB / 4);
	localparam int DC_N = $clog2(DCACHE_KB / 4);
	localparam logic [31:0] IC_TAG_KEEP = ~((32'h1 << IC_N) - 32'h1);
	localparam logic [31:0] DC_TAG_KEEP = ~((32'h1 << DC_N) - 32'h1);
	localparam logic [31:0] MASK_IC_LOC = 32'h40000000 | ((32'h1 << (IC_N + 11)) - 32'h1)
		& 32'hFFFFFFFD;
	localparam logic [31:0] MASK_DC_LOC = 32'hC0000000 | ((32'h1 << (DC_N + 10)) - 32'h1)
		& 32'hFFFFFFFD;
	localparam bit IC_EB = ICACHE_PRESENT && ECC_PRESENT;
	localparam bit DC_EB = DCACHE_PRESENT && ECC_PRESENT;

	typedef struct packed {
		logic [1:0][31:0] ic_err;
		logic [1:0][31:0] dc_err;
		logic [1:0][31:0] tm_err;
		logic [1:0][31:0] tm_dat;
		logic [31:0] ic_loc;
		logic [31:0] dc_loc;
		logic [31:0] rdata;
		logic fault;
	} cde_state_type;

	cde_state_type s_q;
	cde_state_type s_d;
	logic [1:0] rst_sync_q;
	logic rstn;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	// pick a hardware target: an unlocked invalid entry first, else unlocked
	function automatic logic [1:0] alloc_pick(input logic [1:0][31:0] e);
		logic [1:0] pick;
		pick = 2'h0;
		if (!e[0][BIT_LOCK] && !e[0][BIT_VALID])
			pick = 2'h1;
		else if (!e[1][BIT_LOCK] && !e[1][BIT_VALID])
			pick = 2'h2;
		else if (!e[0][BIT_LOCK])
			pick = 2'h1;
		else if (!e[1][BIT_LOCK])
			pick = 2'h2;
		return pick;
	endfunction : alloc_pick

	// software write into an entry pair, lock kept exclusive
	function automatic logic [31:0] entry_wr(input logic [31:0] cur, input logic [31:0] other,
		input logic [31:0] wd, input logic [31:0] mask);
		logic [31:0] nv;
		nv = (cur & ~mask) | (wd & mask);
		if (other[BIT_LOCK])
			nv[BIT_LOCK] = cur[BIT_LOCK];
		return nv;
	endfunction : entry_wr

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	// cold reset released through two flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rstn = rst_sync_q[1];

	// ----------------------------------------------------------------
	// access qualification
	// ----------------------------------------------------------------
	logic setup_ph;
	logic wr_ph;
	logic priv;
	logic eb_ok;
	logic dca_ok;
	logic ic_rd_ok;
	logic dc_rd_ok;
	logic [1:0] ic_pick;
	logic [1:0] dc_pick;
	logic [1:0] tm_pick;

	// access phases and privilege
	assign setup_ph = psel && !penable;
	assign priv = pprot[0];
	assign wr_ph = psel && penable && pwrite && priv;
	assign eb_ok = !(SECURITY_EXT && pprot[1] && !nonsecure_fault_handling_control);
	assign dca_ok = !(SECURITY_EXT && pprot[1]);
	assign ic_rd_ok = ICACHE_PRESENT && dca_ok && icache_active_control
		&& cache_ram_power_domain && !cache_auto_invalidating;
	assign dc_rd_ok = DCACHE_PRESENT && dca_ok && dcache_active_control
		&& cache_ram_power_domain && !cache_auto_invalidating;
	assign ic_pick = alloc_pick(s_q.ic_err);
	assign dc_pick = alloc_pick(s_q.dc_err);
	assign tm_pick = alloc_pick(s_q.tm_err);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		// read value captured in the setup cycle
		if (setup_ph)
		begin
			s_d.rdata = 32'h0;
			s_d.fault = 1'b0;
			unique case (paddr)
				ADDR_IC_ERR0, ADDR_IC_ERR1, ADDR_DC_ERR0, ADDR_DC_ERR1,
				ADDR_TM_ERR0, ADDR_TM_DAT0, ADDR_TM_ERR1, ADDR_TM_DAT1:
				begin
					s_d.fault = !priv;
					if (eb_ok && priv)
					begin
						unique case (paddr)
							ADDR_IC_ERR0: s_d.rdata = s_q.ic_err[0];
							ADDR_IC_ERR1: s_d.rdata = s_q.ic_err[1];
							ADDR_DC_ERR0: s_d.rdata = s_q.dc_err[0];
							ADDR_DC_ERR1: s_d.rdata = s_q.dc_err[1];
							ADDR_TM_ERR0: s_d.rdata = s_q.tm_err[0];
							ADDR_TM_DAT0: s_d.rdata = s_q.tm_dat[0];
							ADDR_TM_ERR1: s_d.rdata = s_q.tm_err[1];
							default: s_d.rdata = s_q.tm_dat[1];
						endcase
					end
				end
				ADDR_IC_READ:
				begin
					s_d.fault = !priv;
					if (ic_rd_ok && priv && s_q.ic_loc[BIT_RAMSEL])
						s_d.rdata = ic_ram_data;
					else if (ic_rd_ok && priv)
						s_d.rdata = {10'h000, ic_ram_tag_valid, ic_ram_tag & IC_TAG_KEEP[20:0]};
				end
				ADDR_DC_READ:
				begin
					s_d.fault = !priv;
					if (dc_rd_ok && priv && s_q.dc_loc[BIT_RAMSEL])
						s_d.rdata = dc_ram_data;
					else if (dc_rd_ok && priv)
						s_d.rdata = {6'h00, dc_ram_attr, dc_ram_tag_valid,
							dc_ram_tag & DC_TAG_KEEP[21:0]};
				end
				ADDR_IC_LOC:
				begin
					s_d.fault = !priv;
					if (ICACHE_PRESENT && dca_ok && priv)
						s_d.rdata = s_q.ic_loc;
				end
				ADDR_DC_LOC:
				begin
					s_d.fault = !priv;
					if (DCACHE_PRESENT && dca_ok && priv)
						s_d.rdata = s_q.dc_loc;
				end
				default: s_d.fault = 1'b1;
			endcase
		end
		if (wr_ph && dca_ok && ICACHE_PRESENT && paddr == ADDR_IC_LOC)
			s_d.ic_loc = pwdata & MASK_IC_LOC;
		if (wr_ph && dca_ok && DCACHE_PRESENT && paddr == ADDR_DC_LOC)
			s_d.dc_loc = pwdata & MASK_DC_LOC;
		// software writes to error entries
		if (wr_ph && eb_ok)
		begin
			if (IC_EB && paddr == ADDR_IC_ERR0)
				s_d.ic_err[0] = entry_wr(s_q.ic_err[0], s_q.ic_err[1], pwdata, MASK_IC_ERR);
			if (IC_EB && paddr == ADDR_IC_ERR1)
				s_d.ic_err[1] = entry_wr(s_q.ic_err[1], s_q.ic_err[0], pwdata, MASK_IC_ERR);
			if (DC_EB && paddr == ADDR_DC_ERR0)
				s_d.dc_err[0] = entry_wr(s_q.dc_err[0], s_q.dc_err[1], pwdata, MASK_DC_ERR);
			if (DC_EB && paddr == ADDR_DC_ERR1)
				s_d.dc_err[1] = entry_wr(s_q.dc_err[1], s_q.dc_err[0], pwdata, MASK_DC_ERR);
			if (ECC_PRESENT && paddr == ADDR_TM_ERR0)
				s_d.tm_err[0] = entry_wr(s_q.tm_err[0], s_q.tm_err[1], pwdata, MASK_TM_ERR);
			if (ECC_PRESENT && paddr == ADDR_TM_ERR1)
				s_d.tm_err[1] = entry_wr(s_q.tm_err[1], s_q.tm_err[0], pwdata, MASK_TM_ERR);
		end
		// hardware allocation wins over a same-cycle software write
		for (int i = 0; i < 2; i++)
		begin
			if (IC_EB && ic_err_valid && ic_pick[i])
				s_d.ic_err[i] = {2'h0, 13'h0000, ic_err_bank, ic_err_location, 1'b0, 1'b1};
			if (DC_EB && dc_err_valid && dc_pick[i])
				s_d.dc_err[i] = {2'h0, 12'h000, dc_err_multi, dc_err_bank, dc_err_location,
					1'b0, 1'b1};
			if (ECC_PRESENT && tm_err_valid && tm_pick[i])
			begin
				s_d.tm_err[i] = {3'h0, tm_err_info[28:2], 1'b0, 1'b1};
				s_d.tm_dat[i] = tm_err_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// only the cold reset clears the entries
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q.ic_err <= {2{RST_ENTRY}};
			s_q.dc_err <= {2{RST_ENTRY}};
			s_q.tm_err <= {2{RST_ENTRY}};
			s_q.tm_dat <= {2{RST_ENTRY}};
			s_q.ic_loc <= RST_LOC;
			s_q.dc_loc <= RST_LOC;
			s_q.rdata <= 32'h0;
			s_q.fault <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// zero-wait access phase
	assign pready = psel && penable;
	assign pslverr = psel && penable && s_q.fault;
	assign prdata = s_q.rdata;
	assign icache_read_location = s_q.ic_loc;
	assign dcache_read_location = s_q.dc_loc;
	// no allocatable entry left
	assign ic_err_full = IC_EB && ic_pick == 2'h0;
	assign dc_err_full = DC_EB && dc_pick == 2'h0;
	assign tm_err_full = ECC_PRESENT && tm_pick == 2'h0;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cde_cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	AST_UNPRIV_FAULT: assert property (
		setup_ph && !priv && paddr == ADDR_IC_ERR0 ##1 penable && psel
		|-> pslverr && prdata == 32'h0)
		else $error("unprivileged access did not fault");

	AST_IC_ONE_LOCK: assert property (!(s_q.ic_err[0][BIT_LOCK] && s_q.ic_err[1][BIT_LOCK]))
		else $error("both icache entries locked");

	AST_DC_ONE_LOCK: assert property (!(s_q.dc_err[0][BIT_LOCK] && s_q.dc_err[1][BIT_LOCK]))
		else $error("both dcache entries locked");

	AST_IC_ALLOC: assert property (
		IC_EB && ic_err_valid && ic_pick[0] |=>
		(s_q.ic_err[0] & MASK_SOFTWARE_DEFINED_FIELD) == 32'h0 && s_q.ic_err[0][BIT_VALID]
		&& s_q.ic_err[0][15:2] == $past(ic_err_location))
		else $error("icache allocation wrong");

	AST_DC_TYPE: assert property (
		DC_EB && dc_err_valid && dc_pick[1] |=>
		s_q.dc_err[1][BIT_DC_TYPE] == $past(dc_err_multi)
		&& s_q.dc_err[1][16] == $past(dc_err_bank))
		else $error("dcache error type not recorded");

	// locked entry left alone by hardware
	AST_LOCK_HOLD: assert property (
		s_q.ic_err[0][BIT_LOCK] && !wr_ph |=> $stable(s_q.ic_err[0]))
		else $error("locked icache entry changed");

	AST_NS_RAZ: assert property (
		setup_ph && !eb_ok && paddr == ADDR_DC_ERR0 |=> prdata == 32'h0)
		else $error("non-secure read of error entry not zero");

	AST_IC_INACTIVE: assert property (
		setup_ph && !icache_active_control && paddr == ADDR_IC_READ |=> prdata == 32'h0)
		else $error("inactive icache read not zero");

	AST_NO_ECC: assert property (
		!s_q.dc_err[0][BIT_VALID] && !(DC_EB && dc_err_valid && dc_pick[0])
		&& !(DC_EB && wr_ph && eb_ok && paddr == ADDR_DC_ERR0)
		|=> !s_q.dc_err[0][BIT_VALID])
		else $error("dcache entry turned valid without cause");

	AST_IC_TAG_LOW: assert property (
		setup_ph && paddr == ADDR_IC_READ && !s_q.ic_loc[BIT_RAMSEL]
		|=> (prdata & ~IC_TAG_KEEP) == 32'h0 && prdata[31:22] == 10'h000)
		else $error("icache tag read has stray bits");

	AST_DC_DATA: assert property (
		setup_ph && dc_rd_ok && priv && paddr == ADDR_DC_READ && s_q.dc_loc[BIT_RAMSEL]
		|=> prdata == $past(dc_ram_data))
		else $error("dcache data word not returned");

	AST_NS_DCA_RAZ: assert property (
		setup_ph && !dca_ok && paddr == ADDR_DC_READ |=> prdata == 32'h0)
		else $error("non-secure direct read not zero");
endmodule : cde_regs

// file: tb/cde_ram_model.sv
// behavioural model of the cache RAMs seen by direct reads
`timescale 1ns/1ps
module cde_ram_model (
	// selected locations
	input wire logic [31:0] ic_loc,
	input wire logic [31:0] dc_loc,
	// icache RAM contents
	output logic ic_valid,
	output logic [20:0] ic_tag,
	output logic [31:0] ic_data,
	// dcache RAM contents
	output logic [2:0] dc_attr,
	output logic dc_valid,
	output logic [21:0] dc_tag,
	output logic [31:0] dc_data
);
	// ----------------------------------------------------------------
	// contents
	// ----------------------------------------------------------------
	// the word depends on location bits 15:0 only; locations differing only above bit 15 hold the same word
	function automatic logic [31:0] pat(input logic [31:0] l);
		return {l[15:0], ~l[15:0]} ^ 32'hA5C30F96;
	endfunction : pat
	always_comb
	begin
		ic_data = pat(ic_loc);
		ic_valid = ic_data[21];
		ic_tag = ic_data[20:0];
		dc_data = pat(dc_loc);
		dc_attr = dc_loc[4:2]; // offset walks all attribute codes
		dc_valid = dc_data[22];
		dc_tag = dc_data[21:0];
	end
endmodule : cde_ram_model

// file: tb/tb.sv
// self-checking bench for the cache diagnostic and error bank registers
`timescale 1ns/1ps
module tb;
	import cde_pkg::*;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, icl, dcl, icd, dcd, seed, ted;
	logic [2:0] pprot, dca, full;
	logic nsfc, ica, dcac, pwr, inv, icv, dcv, iev, ieb, dev, dem, deb, tev;
	logic [20:0] ict;
	logic [21:0] dct;
	logic [13:0] iel, del;
	logic [28:2] tei;
	int error_cnt, checks_done;
	logic [33:0] notes [$];
	logic [31:0] ea [8] = '{ADDR_IC_ERR0, ADDR_IC_ERR1, ADDR_DC_ERR0, ADDR_DC_ERR1,
		ADDR_TM_ERR0, ADDR_TM_DAT0, ADDR_TM_ERR1, ADDR_TM_DAT1};
	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	cde_regs uut (
		.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nonsecure_fault_handling_control(nsfc),
		.icache_active_control(ica), .dcache_active_control(dcac),
		.cache_ram_power_domain(pwr), .cache_auto_invalidating(inv),
		.icache_read_location(icl), .dcache_read_location(dcl),
		.ic_ram_tag_valid(icv), .ic_ram_tag(ict), .ic_ram_data(icd), .dc_ram_attr(dca),
		.dc_ram_tag_valid(dcv), .dc_ram_tag(dct), .dc_ram_data(dcd),
		.ic_err_valid(iev), .ic_err_bank(ieb), .ic_err_location(iel),
		.dc_err_valid(dev), .dc_err_multi(dem), .dc_err_bank(deb), .dc_err_location(del),
		.tm_err_valid(tev), .tm_err_info(tei), .tm_err_data(ted),
		.ic_err_full(full[0]), .dc_err_full(full[1]), .tm_err_full(full[2])
	);
	cde_ram_model u_ram (
		.ic_loc(icl), .dc_loc(dcl), .ic_valid(icv), .ic_tag(ict), .ic_data(icd),
		.dc_attr(dca), .dc_valid(dcv), .dc_tag(dct), .dc_data(dcd)
	);
	// clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic wrap_up();
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// expected entry after a hardware allocation
	function automatic logic [31:0] ent(input int c, input logic [15:0] r);
		return {14'h0, (c == 1) & r[15], r[14], r[13:0], 2'h1};
	endfunction : ent
	// one apb transfer, expectation noted first
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic er);
		int k;
		notes.push_back({~w, er, e});
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			error_cnt++;
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic er = 1'b0);
		apb(1'b0, a, 32'h0, e, er);
	endtask : rd
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic er = 1'b0);
		apb(1'b1, a, d, 32'h0, er);
	endtask : wr
	// one error event pulse from the detection logic
	task automatic ev(input int c, input logic [15:0] r);
		@(posedge clk);
		ieb <= r[14];
		deb <= r[14];
		dem <= r[15];
		iel <= r[13:0];
		del <= r[13:0];
		iev <= (c == 0);
		dev <= (c == 1);
		tev <= (c == 2);
		@(posedge clk);
		{iev, dev, tev} <= 3'h0;
	endtask : ev
	// compare each finished transfer with the oldest note
	always @(posedge clk)
	begin
		logic [33:0] n;
		if (psel && penable && pready)
		begin
			n = notes.pop_front();
			check({31'h0, pslverr}, {31'h0, n[32]});
			if (n[33])
				check(prdata, n[31:0]);
		end
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] r, a, l, w, e;
		logic [31:0] x [3];
		{psel, penable, pwrite, iev, ieb, dev, dem, deb, tev, nsfc, inv} = '0;
		{paddr, pwdata, iel, del, tei, ted} = '0;
		{resetn, ica, dcac, pwr, pprot} = 7'h39;
		seed = 32'h40;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (ea[i]) rd(ea[i], RST_ENTRY);
		rd(32'hE001E108, 32'h0, 1'b1);
		pprot <= 3'h0;
		rd(ADDR_IC_ERR0, 32'h0, 1'b1);
		wr(ADDR_IC_ERR0, 32'h3, 1'b1);
		pprot <= 3'h1;
		rd(ADDR_IC_ERR0, 32'h0);
		for (int c = 0; c < 2; c++)
		begin
			a = c ? ADDR_DC_ERR0 : ADDR_IC_ERR0;
			for (int k = 0; k < 3; k++)
			begin
				r = rnd();
				x[k] = ent(c, r[15:0]);
				ev(c, r[15:0]);
			end
			rd(a, x[2]);
			rd(a + 4, x[1]);
			wr(a, 32'hC0000003);
			rd(a, 32'hC0000003);
			wr(a + 4, 32'hC0000003);
			rd(a + 4, 32'hC0000001);
			r = rnd();
			ev(c, r[15:0]);
			rd(a + 4, ent(c, r[15:0]));
			rd(a, 32'hC0000003);
			check({29'h0, full}, 32'h0);
			pprot <= 3'h3;
			rd(a, 32'h0);
			wr(a, 32'h0);
			nsfc <= 1'b1;
			rd(a, 32'hC0000003);
			nsfc <= 1'b0;
			pprot <= 3'h1;
		end
		r = rnd();
		w = rnd();
		tei <= r[28:2];
		ted <= w;
		ev(2, 16'h0);
		rd(ADDR_TM_ERR0, {3'h0, r[28:2], 2'h1});
		wr(ADDR_TM_DAT0, ~w);
		rd(ADDR_TM_DAT0, w);
		for (int c = 0; c < 2; c++)
			for (int k = 0; k < 16; k++)
			begin
				r = rnd();
				l = (r & (c ? 32'hC0003FE0 : 32'h40007FE0)) | {27'h0, k[3:1], 1'b0, k[0]};
				w = u_ram.pat(l);
				wr(c ? ADDR_DC_LOC : ADDR_IC_LOC, l);
				rd(c ? ADDR_DC_LOC : ADDR_IC_LOC, l);
				e = c ? {6'h0, l[4:2], w[22:4], 4'h0} : {10'h0, w[21:4], 4'h0};
				rd(c ? ADDR_DC_READ : ADDR_IC_READ, k[0] ? w : e);
			end
		for (int k = 0; k < 4; k++)
		begin
			ica <= (k != 0);
			dcac <= (k != 0);
			pwr <= (k != 1);
			inv <= (k == 2);
			pprot <= (k == 3) ? 3'h3 : 3'h1;
			rd(ADDR_IC_READ, 32'h0);
			rd(ADDR_DC_READ, 32'h0);
		end
		{ica, dcac, pwr, inv, pprot} <= 7'h71;
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (ea[i]) rd(ea[i], RST_ENTRY);
		repeat (2) @(posedge clk);
		wrap_up();
	end
endmodule : tb
